// ---- rtl/scm_defines.svh ----
// Offsets, reset values, field positions and timing counts of the block.
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH

// Clock period and the one millisecond time base, in nanoseconds.
`define SCM_CLK_PERIOD_NS 4
`define SCM_MS_NS 1000000
`define SCM_CYC_PER_MS (`SCM_MS_NS / `SCM_CLK_PERIOD_NS)

// Rated motor speed in rpm, the reference for the ramp slope.
`define SCM_RATED_RPM 3000

// Register byte offsets on the bus.
`define SCM_OFS_JOG 8'h00
`define SCM_OFS_ACC_T 8'h04
`define SCM_OFS_DEC_T 8'h08
`define SCM_OFS_MATCH 8'h0c
`define SCM_OFS_REACH 8'h10
`define SCM_OFS_ZERO 8'h14
`define SCM_OFS_ADTHR 8'h18
`define SCM_OFS_FBT 8'h1c
`define SCM_OFS_DISPT 8'h20
`define SCM_OFS_FILT 8'h24
`define SCM_OFS_DISP 8'h28
`define SCM_OFS_CMD 8'h2c
`define SCM_OFS_LIVE 8'h30
`define SCM_OFS_IST 8'h34
`define SCM_OFS_IMASK 8'h38

// Reset values of the writable registers.
`define SCM_JOG_RST 16'h0014
`define SCM_ACC_T_RST 16'h01f4
`define SCM_DEC_T_RST 16'h01f4
`define SCM_MATCH_RST 16'h000a
`define SCM_REACH_RST 16'h03e8
`define SCM_ZERO_RST 16'h0005
`define SCM_ADTHR_RST 16'h000a
`define SCM_FBT_RST 16'h0001
`define SCM_DISPT_RST 16'h012c
`define SCM_IMASK_RST 7'h00

// Bit positions of the status outputs in live, status and mask words.
`define SCM_B_MATCH 0
`define SCM_B_REACH 1
`define SCM_B_ZERO 2
`define SCM_B_ACC 3
`define SCM_B_DEC 4
`define SCM_B_FWD 5
`define SCM_B_REV 6

`endif

// ---- rtl/scm_pkg.sv ----
// Types shared by the speed command and status logic.
`default_nettype none
package scm_pkg;

	// Whole state of the first-order filter.
	typedef struct packed {
		logic signed [15:0] y;
		logic signed [35:0] acc;
	} scm_lpf_state_t;

	// State of the core module, apart from the reset release flops and the two filters.
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [15:0] jog;
		logic [15:0] acc_t;
		logic [15:0] dec_t;
		logic [15:0] match;
		logic [15:0] reach;
		logic [15:0] zero;
		logic [15:0] adthr;
		logic [15:0] fbt;
		logic [15:0] dispt;
		logic [6:0] mask;
		logic [6:0] ist;
		logic [6:0] outs;
		logic signed [15:0] cmd_ref;
		logic [35:0] racc;
		logic [31:0] ms;
		logic [16:0] prev_abs;
		logic irq;
	} scm_state_t;

endpackage
`default_nettype wire

// ---- rtl/scm_lpf.sv ----
// First-order low-pass filter built on an error accumulator.
`timescale 1ns/1ns
`default_nettype none
module scm_lpf
	import scm_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic signed [15:0] i_x,
	input wire logic [35:0] i_limit,
	output logic signed [15:0] o_y
);

	scm_lpf_state_t s;
	scm_lpf_state_t n;
	logic signed [35:0] sum;
	logic signed [35:0] lim;

	////////////////////////////////////////////////////////////////////////
	// Each cycle the error adds to the accumulator; one rpm step is taken
	// per limit's worth, so dy/dt equals error over limit cycles. This
	// avoids a divider at the cost of one rpm resolution.
	always_comb begin
		n = s;
		lim = $signed(i_limit);
		sum = s.acc + (36'(i_x) - 36'(s.y));
		if (i_limit == 36'h0_0000_0000) begin
			n.y = i_x;
			n.acc = '0;
		end else if (sum >= lim) begin
			n.y = s.y + 16'sd1;
			n.acc = sum - lim;
		end else if (sum <= -lim) begin
			n.y = s.y - 16'sd1;
			n.acc = sum + lim;
		end else begin
			n.acc = sum;
		end
	end

	// State register.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign o_y = s.y;

endmodule // scm_lpf
`default_nettype wire

// ---- rtl/scm_core.sv ----
// Speed command modifiers, ramp, speed filters and speed status outputs.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.svh"
module scm_core
	import scm_pkg::*;
#(
	parameter int CYC_PER_MS = `SCM_CYC_PER_MS,
	parameter int RATED_RPM = `SCM_RATED_RPM
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_speed_mode,
	input wire logic signed [15:0] i_speed_cmd,
	input wire logic signed [15:0] i_speed_fb,
	input wire logic i_command_invert_input,
	input wire logic i_command_pause_input,
	input wire logic i_forward_jog_input,
	input wire logic i_reverse_jog_input,
	output logic signed [15:0] o_speed_ref,
	output logic signed [15:0] o_filtered_actual_speed,
	output logic signed [15:0] o_display_speed,
	output logic o_speed_match_output,
	output logic o_speed_reached_output,
	output logic o_zero_speed_output,
	output logic o_accelerating_output,
	output logic o_decelerating_output,
	output logic o_forward_rotation_output,
	output logic o_reverse_rotation_output,
	output logic o_irq
);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Converts a time in milliseconds to clock cycles.
	function automatic logic [35:0] ms_to_cyc(input logic [15:0] t);
		return 36'(t) * 36'(CYC_PER_MS);
	endfunction

	// Magnitude of a signed 16-bit speed, one bit wider so -32768 fits.
	function automatic logic [16:0] mag(input logic signed [15:0] v);
		return v[15] ? 17'(-18'(v)) : 17'(v);
	endfunction

	// Clamps an 18-bit signed sum into the 16-bit speed range.
	function automatic logic signed [15:0] sat16(
		input logic signed [17:0] v);
		if (v > 18'sd32767) begin
			return 16'sh7fff;
		end else if (v < -18'sd32768) begin
			return 16'sh8000;
		end else begin
			return v[15:0];
		end
	endfunction

	// Byte-lane merge of a 16-bit register with a bus write.
	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// Word offset of a bus address; the two byte bits are ignored.
	function automatic logic [7:0] word_ofs(input logic [7:0] a);
		return {a[7:2], 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	// Reset asserts at once but leaves only on a clock edge, so no flop
	// sees its release inside a setup window.

	logic [1:0] rst_sync;
	logic rst_n;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////
	// Speed filters.

	scm_state_t s;
	scm_state_t n;
	logic signed [15:0] filt;
	logic signed [15:0] disp;
	logic [35:0] fb_lim;
	logic [35:0] disp_lim;

	// The two filters have independent time constants from software.
	// A time of zero passes the feedback straight through, one cycle late.
	assign fb_lim = ms_to_cyc(s.fbt);
	assign disp_lim = ms_to_cyc(s.dispt);

	// Feedback filter producing the filtered actual speed.
	scm_lpf u_fb_lpf (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_x(i_speed_fb),
		.i_limit(fb_lim),
		.o_y(filt)
	);

	// Display filter, fed from raw feedback so it never slows status.
	scm_lpf u_disp_lpf (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_x(i_speed_fb),
		.i_limit(disp_lim),
		.o_y(disp)
	);

	////////////////////////////////////////////////////////////////////////
	// Combinational next-state signals.

	logic signed [16:0] inv_cmd;
	logic signed [16:0] jog_add;
	logic signed [15:0] target;
	logic away;
	logic [35:0] ramp_lim;
	logic [35:0] ramp_sum;
	logic ms_tick;
	logic [16:0] fmag;
	logic [16:0] err_mag;
	logic [6:0] rise;
	logic req;
	logic rd_ist;
	logic [31:0] rd_val;

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped offsets read as zero.
	// The data is taken when the request is seen, so the answer shows
	// the registers as they stood one cycle before ack.
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (word_ofs(i_wb_adr))
			`SCM_OFS_JOG: rd_val = {16'h0000, s.jog};
			`SCM_OFS_ACC_T: rd_val = {16'h0000, s.acc_t};
			`SCM_OFS_DEC_T: rd_val = {16'h0000, s.dec_t};
			`SCM_OFS_MATCH: rd_val = {16'h0000, s.match};
			`SCM_OFS_REACH: rd_val = {16'h0000, s.reach};
			`SCM_OFS_ZERO: rd_val = {16'h0000, s.zero};
			`SCM_OFS_ADTHR: rd_val = {16'h0000, s.adthr};
			`SCM_OFS_FBT: rd_val = {16'h0000, s.fbt};
			`SCM_OFS_DISPT: rd_val = {16'h0000, s.dispt};
			`SCM_OFS_FILT: rd_val = {16'h0000, filt};
			`SCM_OFS_DISP: rd_val = {16'h0000, disp};
			`SCM_OFS_CMD: rd_val = {16'h0000, s.cmd_ref};
			`SCM_OFS_LIVE: rd_val = {25'h000_0000, s.outs};
			`SCM_OFS_IST: rd_val = {25'h000_0000, s.ist};
			`SCM_OFS_IMASK: rd_val = {25'h000_0000, s.mask};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: command path, ramp, status, interrupts and bus.
	always_comb begin
		n = s;
		req = i_wb_cyc & i_wb_stb;
		rd_ist = 1'b0;
		ramp_lim = '0;
		ramp_sum = '0;
		away = 1'b0;

		// Command modifiers: invert, then jog offset in speed mode.
		inv_cmd = i_command_invert_input ? -17'(i_speed_cmd)
			: 17'(i_speed_cmd);
		jog_add = '0;
		if (i_speed_mode && i_forward_jog_input && !i_reverse_jog_input) begin
			jog_add = 17'(s.jog);
		end else if (i_speed_mode && i_reverse_jog_input
			&& !i_forward_jog_input) begin
			jog_add = -17'(s.jog);
		end
		target = sat16(18'(inv_cmd) + 18'(jog_add));

		// Ramp: a Bresenham walk, one rpm per ramp time worth of rated
		// speed. Moving away from zero uses the acceleration time.
		// Limitation: at most one rpm per cycle, so the rated speed must
		// not exceed the shortest nonzero ramp time counted in cycles.
		if (i_command_pause_input) begin
			n.cmd_ref = '0;
			n.racc = '0;
		end else if (target == s.cmd_ref) begin
			n.racc = '0;
		end else begin
			away = (target > s.cmd_ref) ? (s.cmd_ref >= 16'sd0)
				: (s.cmd_ref <= 16'sd0);
			ramp_lim = ms_to_cyc(away ? s.acc_t : s.dec_t);
			ramp_sum = s.racc + 36'(RATED_RPM);
			if (ramp_lim == '0) begin
				n.cmd_ref = target;
				n.racc = '0;
			end else if (ramp_sum >= ramp_lim) begin
				n.cmd_ref = (target > s.cmd_ref) ? s.cmd_ref + 16'sd1
					: s.cmd_ref - 16'sd1;
				n.racc = ramp_sum - ramp_lim;
			end else begin
				n.racc = ramp_sum;
			end
		end

		// Millisecond time base for the acceleration measurement.
		ms_tick = (s.ms == 32'(CYC_PER_MS - 1));
		n.ms = ms_tick ? 32'h0000_0000 : s.ms + 32'h0000_0001;

		// Level status outputs; speed match is compared against the applied command.
		// They lag the filtered speed by one cycle, which keeps every
		// output straight from a flip-flop.
		fmag = mag(filt);
		err_mag = mag(sat16(18'(filt) - 18'(s.cmd_ref)));
		n.outs[`SCM_B_MATCH] = err_mag < 17'(s.match);
		n.outs[`SCM_B_REACH] = fmag > 17'(s.reach);
		n.outs[`SCM_B_ZERO] = fmag < 17'(s.zero);
		n.outs[`SCM_B_FWD] = 17'(filt) > $signed({1'b0, s.zero});
		n.outs[`SCM_B_REV] = 17'(filt) < -$signed({1'b0, s.zero});

		// Acceleration is the change of magnitude per millisecond.
		// Changes inside one millisecond are not seen; this trades speed
		// of response for a small comparator and no divider.
		if (ms_tick) begin
			n.prev_abs = fmag;
			n.outs[`SCM_B_ACC] = (fmag > s.prev_abs)
				&& (fmag - s.prev_abs > 17'(s.adthr));
			n.outs[`SCM_B_DEC] = (s.prev_abs > fmag)
				&& (s.prev_abs - fmag > 17'(s.adthr));
		end

		// Wishbone: ack one cycle after the request; a write and the
		// status read-clear act on the edge where the master sees ack.
		if (req && !s.ack) begin
			n.ack = 1'b1;
			n.rdat = rd_val;
		end else if (s.ack) begin
			n.ack = 1'b0;
			if (req && i_wb_we) begin
				// Only sel[1:0] matter: no writable register is wider.
				unique case (word_ofs(i_wb_adr))
					`SCM_OFS_JOG: n.jog = wr16(s.jog, i_wb_dat, i_wb_sel);
					`SCM_OFS_ACC_T:
						n.acc_t = wr16(s.acc_t, i_wb_dat, i_wb_sel);
					`SCM_OFS_DEC_T:
						n.dec_t = wr16(s.dec_t, i_wb_dat, i_wb_sel);
					`SCM_OFS_MATCH:
						n.match = wr16(s.match, i_wb_dat, i_wb_sel);
					`SCM_OFS_REACH:
						n.reach = wr16(s.reach, i_wb_dat, i_wb_sel);
					`SCM_OFS_ZERO: n.zero = wr16(s.zero, i_wb_dat, i_wb_sel);
					`SCM_OFS_ADTHR:
						n.adthr = wr16(s.adthr, i_wb_dat, i_wb_sel);
					`SCM_OFS_FBT: n.fbt = wr16(s.fbt, i_wb_dat, i_wb_sel);
					`SCM_OFS_DISPT:
						n.dispt = wr16(s.dispt, i_wb_dat, i_wb_sel);
					`SCM_OFS_IMASK: begin
						if (i_wb_sel[0]) begin
							n.mask = i_wb_dat[6:0];
						end
					end
					default: begin
					end
				endcase
			end else if (req && (word_ofs(i_wb_adr) == `SCM_OFS_IST)) begin
				rd_ist = 1'b1;
			end
		end

		// Sticky events on each rising status output; a new event in
		// the clearing cycle survives, since it is ORed in after.
		rise = n.outs & ~s.outs;
		n.ist = (rd_ist ? 7'h00 : s.ist) | rise;
		n.irq = |(n.ist & n.mask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register with the documented reset values.
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.jog <= `SCM_JOG_RST;
			s.acc_t <= `SCM_ACC_T_RST;
			s.dec_t <= `SCM_DEC_T_RST;
			s.match <= `SCM_MATCH_RST;
			s.reach <= `SCM_REACH_RST;
			s.zero <= `SCM_ZERO_RST;
			s.adthr <= `SCM_ADTHR_RST;
			s.fbt <= `SCM_FBT_RST;
			s.dispt <= `SCM_DISPT_RST;
			s.mask <= `SCM_IMASK_RST;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops.
	assign o_wb_dat = s.rdat;
	assign o_wb_ack = s.ack;
	assign o_speed_ref = s.cmd_ref;
	assign o_filtered_actual_speed = filt;
	assign o_display_speed = disp;
	assign o_speed_match_output = s.outs[`SCM_B_MATCH];
	assign o_speed_reached_output = s.outs[`SCM_B_REACH];
	assign o_zero_speed_output = s.outs[`SCM_B_ZERO];
	assign o_accelerating_output = s.outs[`SCM_B_ACC];
	assign o_decelerating_output = s.outs[`SCM_B_DEC];
	assign o_forward_rotation_output = s.outs[`SCM_B_FWD];
	assign o_reverse_rotation_output = s.outs[`SCM_B_REV];
	assign o_irq = s.irq;

endmodule // scm_core
`default_nettype wire

// ---- verification/scm_core_chk.sv ----
// Port checks of the speed command and status block.
`timescale 1ns/1ns
`default_nettype none
module scm_core_chk #(
	parameter int CYC_PER_MS = 250000,
	parameter int RATED_RPM = 3000
)
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_command_pause_input,
	input wire logic o_wb_ack,
	input wire logic signed [15:0] o_speed_ref,
	input wire logic signed [15:0] o_filtered_actual_speed,
	input wire logic o_speed_reached_output,
	input wire logic o_zero_speed_output,
	input wire logic o_accelerating_output,
	input wire logic o_decelerating_output,
	input wire logic o_forward_rotation_output,
	input wire logic o_reverse_rotation_output
);
	//////////////////////////////////////////////////
	// Status levels follow the filtered speed of the cycle before.
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
		|=> o_wb_ack) else $error("request not answered");
	ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	pause_zero_a: assert property (
		i_command_pause_input |=> o_speed_ref == 16'h0000)
		else $error("pause did not zero the command");
	fwd_sign_a: assert property (
		o_forward_rotation_output |-> $past(o_filtered_actual_speed) > 0)
		else $error("forward with no positive speed");
	rev_sign_a: assert property (
		o_reverse_rotation_output |-> $past(o_filtered_actual_speed) < 0)
		else $error("reverse with no negative speed");
	reach_nonzero_a: assert property (
		o_speed_reached_output |-> $past(o_filtered_actual_speed) != 0)
		else $error("reached at standstill");
	zero_excl_a: assert property (
		o_zero_speed_output |-> !o_forward_rotation_output
		&& !o_reverse_rotation_output) else $error("zero while turning");
	acc_dec_a: assert property (
		!(o_accelerating_output && o_decelerating_output))
		else $error("accelerating and decelerating");
	cover property (i_command_pause_input ##1 o_speed_ref == 16'h0000);
	cover property (o_forward_rotation_output);
	cover property (o_accelerating_output);
endmodule // scm_core_chk
bind scm_core scm_core_chk #(.CYC_PER_MS(CYC_PER_MS), .RATED_RPM(RATED_RPM))
	i_scm_core_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_command_pause_input(i_command_pause_input), .o_wb_ack(o_wb_ack),
	.o_speed_ref(o_speed_ref),
	.o_filtered_actual_speed(o_filtered_actual_speed),
	.o_speed_reached_output(o_speed_reached_output),
	.o_zero_speed_output(o_zero_speed_output),
	.o_accelerating_output(o_accelerating_output),
	.o_decelerating_output(o_decelerating_output),
	.o_forward_rotation_output(o_forward_rotation_output),
	.o_reverse_rotation_output(o_reverse_rotation_output));
`default_nettype wire

// ---- verification/scm_host_model.sv ----
// Host side model that drives the digital inputs and speed values.
`timescale 1ns/1ns
`default_nettype none
module scm_host_model (
	input wire logic i_mclk,
	output logic o_mode,
	output logic o_inv,
	output logic o_pause,
	output logic o_fjog,
	output logic o_rjog,
	output logic signed [15:0] o_cmd,
	output logic signed [15:0] o_fb
);
	//////////////////////////////////////////////////
	// Inputs start inactive so that the block leaves reset idle.
	initial begin
		o_mode = 1'b0;
		{o_inv, o_pause, o_fjog, o_rjog} = 4'h0;
		o_cmd = 16'h0000;
		o_fb = 16'h0000;
	end
	// Levels change just after an edge and hold until the next call.
	task automatic drv(input logic m, i, p, f, r,
		input logic signed [15:0] c, b);
		@(posedge i_mclk);
		o_mode <= m;
		{o_inv, o_pause, o_fjog, o_rjog} <= {i, p, f, r};
		o_cmd <= c;
		o_fb <= b;
	endtask
endmodule // scm_host_model
`default_nettype wire

// ---- verification/test_scm_core.sv ----
// Self-checking bench of the speed command and status block.
`timescale 1ns/1ns
`default_nettype none
`include "scm_defines.svh"
module test_scm_core;
	logic mclk, rst_n, cyc, stb, we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, q;
	wire logic [31:0] rdat;
	wire logic ack, mode, inv, pause, fjog, rjog, irq;
	wire logic signed [15:0] cmd, fb, sref, filt, disp;
	wire logic [6:0] st;
	int bad_count, total_checks, n;
	//////////////////////////////////////////////////
	// Short millisecond and a low rated speed keep ramps brief.
	scm_core #(.CYC_PER_MS(50), .RATED_RPM(100)) i_scm_core (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_speed_mode(mode),
		.i_speed_cmd(cmd), .i_speed_fb(fb), .i_command_invert_input(inv),
		.i_command_pause_input(pause), .i_forward_jog_input(fjog),
		.i_reverse_jog_input(rjog), .o_speed_ref(sref),
		.o_filtered_actual_speed(filt), .o_display_speed(disp),
		.o_speed_match_output(st[0]), .o_speed_reached_output(st[1]),
		.o_zero_speed_output(st[2]), .o_accelerating_output(st[3]),
		.o_decelerating_output(st[4]), .o_forward_rotation_output(st[5]),
		.o_reverse_rotation_output(st[6]), .o_irq(irq));
	scm_host_model i_scm_host_model (.i_mclk(mclk), .o_mode(mode),
		.o_inv(inv), .o_pause(pause), .o_fjog(fjog), .o_rjog(rjog),
		.o_cmd(cmd), .o_fb(fb));
	// Free-running clock.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic ck(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// One classic cycle; the request holds until ack is seen.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		{cyc, stb, we, sel} <= {2'b11, w, 4'hf};
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			bad_count++;
			conclude();
		end
		q = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		ck(q, e);
	endtask
	task automatic spd(input logic m, i, p, f, r,
		input logic signed [15:0] c, b, input int w);
		i_scm_host_model.drv(m, i, p, f, r, c, b);
		repeat (w) @(posedge mclk);
	endtask
	task automatic live(input logic signed [15:0] c, b, input logic [6:0] e);
		spd(1, 0, 0, 0, 0, c, b, 5);
		wb(1'b0, `SCM_OFS_LIVE, 32'h0000_0000);
		ck(q & 32'h0000_0067, {25'h0, e});
	endtask
	// Main sequence.
	initial begin
		{rst_n, cyc, stb, we, sel, adr, wdat} = '0;
		bad_count = 0;
		total_checks = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(`SCM_OFS_JOG, 32'h0000_0014);
		rd(`SCM_OFS_ACC_T, 32'h0000_01f4);
		rd(`SCM_OFS_DEC_T, 32'h0000_01f4);
		wb(1'b1, `SCM_OFS_JOG, 32'hffff_1234);
		rd(`SCM_OFS_JOG, 32'h0000_1234);
		wb(1'b1, `SCM_OFS_FILT, 32'h0000_0055);
		rd(`SCM_OFS_FILT, 32'h0000_0000);
		rd(8'h3c, 32'h0000_0000);
		$display("test registers done");
		wb(1'b1, `SCM_OFS_JOG, 32'h0000_0014);
		wb(1'b1, `SCM_OFS_ACC_T, 32'h0000_0000);
		wb(1'b1, `SCM_OFS_DEC_T, 32'h0000_0000);
		wb(1'b1, `SCM_OFS_FBT, 32'h0000_0000);
		spd(1, 1, 0, 0, 0, 100, 0, 4);
		ck(32'(sref), -32'sd100);
		spd(1, 0, 0, 1, 0, 100, 0, 4);
		ck(32'(sref), 32'sd120);
		spd(1, 0, 0, 0, 1, 100, 0, 4);
		ck(32'(sref), 32'sd80);
		spd(1, 0, 0, 1, 1, 100, 0, 4);
		ck(32'(sref), 32'sd100);
		spd(0, 0, 0, 1, 0, 100, 0, 4);
		ck(32'(sref), 32'sd100);
		spd(1, 1, 0, 1, 0, 100, 0, 4);
		ck(32'(sref), -32'sd80);
		spd(1, 0, 1, 1, 0, 100, 0, 2);
		ck(32'(sref), 32'sd0);
		$display("test command done");
		live(100, 100, 7'h21);
		live(100, 1500, 7'h22);
		live(0, 0, 7'h05);
		live(0, -6, 7'h41);
		live(0, 5, 7'h01);
		live(-2000, -1001, 7'h42);
		live(0, -100, 7'h40);
		wb(1'b0, `SCM_OFS_IST, 32'h0000_0000);
		live(0, 100, 7'h20);
		ck(irq, 1'b0);
		wb(1'b1, `SCM_OFS_IMASK, 32'h0000_0020);
		repeat (2) @(posedge mclk);
		ck(irq, 1'b1);
		// The step from standstill to 100 rpm is also seen as acceleration
		// at the next millisecond boundary, so that event is pending too.
		rd(`SCM_OFS_IST, 32'h0000_0028);
		repeat (2) @(posedge mclk);
		ck(irq, 1'b0);
		// Hold a steady speed past a millisecond so that the flag clears.
		spd(1, 0, 0, 0, 0, 0, 100, 60);
		ck(st[3], 1'b0);
		spd(1, 0, 0, 0, 0, 0, 1000, 0);
		for (n = 0; n < 120 && st[3] !== 1'b1; n++) @(posedge mclk);
		ck(n < 120, 1'b1);
		spd(1, 0, 0, 0, 0, 0, 0, 0);
		for (n = 0; n < 120 && st[4] !== 1'b1; n++) @(posedge mclk);
		ck(n < 120, 1'b1);
		$display("test status done");
		spd(1, 0, 0, 0, 0, 0, 0, 150);
		wb(1'b1, `SCM_OFS_FBT, 32'h0000_0002);
		wb(1'b1, `SCM_OFS_DISPT, 32'h0000_0000);
		spd(1, 0, 0, 0, 0, 0, 200, 10);
		ck(32'(disp), 32'sd200);
		ck(filt > 0 && filt < 200, 1'b1);
		$display("test filters done");
		wb(1'b1, `SCM_OFS_ACC_T, 32'h0000_0002);
		spd(1, 0, 0, 0, 0, 60, 0, 30);
		ck(sref > 20 && sref < 40, 1'b1);
		repeat (60) @(posedge mclk);
		ck(32'(sref), 32'sd60);
		// Toward zero uses the deceleration time: 4 ms is 2 cycles per rpm.
		wb(1'b1, `SCM_OFS_DEC_T, 32'h0000_0004);
		spd(1, 0, 0, 0, 0, 0, 0, 60);
		ck(sref > 20 && sref < 40, 1'b1);
		repeat (70) @(posedge mclk);
		ck(32'(sref), 32'sd0);
		$display("test ramp done");
		conclude();
	end
endmodule // test_scm_core
`default_nettype wire
